// ### rtl/pmd_engine.sv
/*
  PCI bus-master engine: burst DMA between shared memory and PCI space, and a
  direct-access path turning register-window accesses into single PCI cycles.
  Assumes PCI signals synchronous to aclk and an external arbiter for req/gnt.
*/
// Function
// - Registers set up bursts between shared memory and PCI
// - Addresses and size ignore two low bits
// - DMA data phases drive all byte enables
// - PCI base spans full 32-bit space
// - Control low-byte write starts the DMA
// - Control bit 0 selects burst direction
// - Pick most efficient burst command
// - Completion sets done bit, pollable
// - Mask bit 21 drives interrupt output
// - Non-prefetch flag forces plain memory read
// - Direct access issues any 4-bit command code
// - Direct register holds base and command
// - PCI address is base plus window offset
// - Window read/write becomes PCI read/write
// - Flags visible and polled from register
`timescale 1ns/100ps
`default_nettype none
module pmd_engine (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [pmd_pkg::MEM_AW-1:0] mem_addr, // Shared memory dword address
  output logic mem_we, // Shared memory write
  output logic [31:0] mem_wdata, // Shared memory write data
  input wire logic [31:0] mem_rdata, // Shared memory data, one cycle late
  output pmd_pkg::pmd_pci_out_type pci_o, // PCI master drive
  input wire logic pci_gnt_n, // Arbiter grant
  input wire logic pci_trdy_n, // Target ready
  input wire logic pci_devsel_n, // Target claimed
  input wire logic pci_stop_n, // Target stop
  input wire logic [31:0] pci_ad_i, // PCI AD in
  output logic irq_out // Local interrupt
);
  localparam int MEM_AW = pmd_pkg::MEM_AW;
  pmd_pkg::pmd_state_type st_q;
  logic [31:0] mem_base_q, pci_base_q, size_q, da_base_q, addr_q, cnt_q, da_rdata_q;
  logic [31:0] da_wdata_q;
  logic [7:0] ctrl_q;
  logic [3:0] da_cmd_q, cmd_q;
  logic done_q, mask_q, busy_q, da_q, da_wr_q, last_q, rd_pend_q, da_resp_q;
  logic aw_q, w_q;
  logic [1:0] wait_q;
  logic [7:0] awaddr_q, ar_q_addr;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic ar_pend_q;
  logic wr_fire, start, da_hit_w, da_hit_r, write_dir;

  assign write_dir = ctrl_q[pmd_pkg::CTRL_DIR];
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;
  assign da_hit_w = (awaddr_q & pmd_pkg::ADDR_DA_MASK) == pmd_pkg::ADDR_DA_WIN;
  assign da_hit_r = (ar_q_addr & pmd_pkg::ADDR_DA_MASK) == pmd_pkg::ADDR_DA_WIN;
  assign start = wr_fire && awaddr_q == pmd_pkg::ADDR_CTRL && wstrb_q[0] && !busy_q;

  // Write address and data captured independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire && !(da_hit_w && busy_q)) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire && !(da_hit_w && busy_q)) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Register writes; a window write is held until the engine is idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_base_q <= 32'h0000_0000;
      pci_base_q <= 32'h0000_0000;
      size_q <= 32'h0000_0000;
      ctrl_q <= 8'h00;
      mask_q <= 1'b0;
      da_base_q <= 32'h0000_0000;
      da_cmd_q <= pmd_pkg::CMD_MEM_RD;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire && !da_hit_w) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= pmd_pkg::RESP_OKAY;
        case (awaddr_q)
          pmd_pkg::ADDR_MEM_BASE: mem_base_q <= wdata_q & pmd_pkg::DWORD_MASK;
          pmd_pkg::ADDR_PCI_BASE: pci_base_q <= wdata_q & pmd_pkg::DWORD_MASK;
          pmd_pkg::ADDR_SIZE: size_q <= wdata_q & pmd_pkg::SIZE_MASK;
          pmd_pkg::ADDR_CTRL: begin
            // Ownership flags are plain storage for software arbitration
            if (wstrb_q[0] && !busy_q) begin
              ctrl_q <= wdata_q[7:0];
            end
          end
          pmd_pkg::ADDR_LOCAL_INTERRUPT_REG: begin
            if (wstrb_q[2]) begin
              mask_q <= wdata_q[pmd_pkg::LOCAL_INTERRUPT_REG_MASK];
            end
          end
          pmd_pkg::ADDR_DA_BASE: da_base_q <= wdata_q & pmd_pkg::DWORD_MASK;
          pmd_pkg::ADDR_DA_CMD: da_cmd_q <= wdata_q[3:0];
          default: s_axi_bresp <= pmd_pkg::RESP_SLVERR;
        endcase
      end else if (da_resp_q && da_wr_q) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= pmd_pkg::RESP_OKAY;
      end
    end
  end

  // Read channel; window reads answer after the PCI cycle ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      ar_pend_q <= 1'b0;
      ar_q_addr <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pmd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !ar_pend_q && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_pend_q <= 1'b1;
        ar_q_addr <= s_axi_araddr;
      end else if (ar_pend_q && !da_hit_r) begin
        ar_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= pmd_pkg::RESP_OKAY;
        case (ar_q_addr)
          pmd_pkg::ADDR_MEM_BASE: s_axi_rdata <= mem_base_q;
          pmd_pkg::ADDR_PCI_BASE: s_axi_rdata <= pci_base_q;
          pmd_pkg::ADDR_SIZE: s_axi_rdata <= size_q;
          pmd_pkg::ADDR_CTRL: s_axi_rdata <= {23'h000000, busy_q, ctrl_q};
          // Completion flag polled here as well as on the pin
          pmd_pkg::ADDR_LOCAL_INTERRUPT_REG: s_axi_rdata <= 32'({mask_q, 15'h0000, done_q, 5'h00});
          pmd_pkg::ADDR_DA_BASE: s_axi_rdata <= da_base_q;
          pmd_pkg::ADDR_DA_CMD: s_axi_rdata <= {28'h0000000, da_cmd_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pmd_pkg::RESP_SLVERR;
          end
        endcase
      end else if (ar_pend_q && da_resp_q && !da_wr_q) begin
        ar_pend_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= da_rdata_q;
      end
    end
  end

  // Done flag: set wins over a software clear of bit 5
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      if (st_q == pmd_pkg::ST_DONE && !da_q) begin
        done_q <= 1'b1;
      end else if (wr_fire && awaddr_q == pmd_pkg::ADDR_LOCAL_INTERRUPT_REG && wstrb_q[0] && wdata_q[pmd_pkg::LOCAL_INTERRUPT_REG_DONE]) begin
        done_q <= 1'b0;
      end
      irq_out <= done_q && mask_q;
    end
  end

  // PCI master sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= pmd_pkg::ST_IDLE;
      busy_q <= 1'b0;
      da_q <= 1'b0;
      da_wr_q <= 1'b0;
      da_resp_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      cnt_q <= 32'h0000_0000;
      cmd_q <= pmd_pkg::CMD_MEM_RD;
      da_rdata_q <= 32'h0000_0000;
      da_wdata_q <= 32'h0000_0000;
      last_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wait_q <= 2'h0;
      mem_addr <= '0;
      mem_we <= 1'b0;
      mem_wdata <= 32'h0000_0000;
      pci_o <= '{req_n: 1'b1, frame_n: 1'b1, irdy_n: 1'b1, ad: 32'h0000_0000, ad_oe: 1'b0, cbe_n: 4'hf};
    end else begin
      mem_we <= 1'b0;
      da_resp_q <= 1'b0;
      // Fill address steps after its write lands, not with it
      if (mem_we) begin
        mem_addr <= mem_addr + 1'b1;
      end
      case (st_q)
        pmd_pkg::ST_IDLE: begin
          if (start && wdata_q[5:2] != 4'h0 && size_q != 32'h0000_0000) begin
            busy_q <= 1'b1;
            da_q <= 1'b0;
            addr_q <= pci_base_q;
            cnt_q <= size_q >> 2;
            mem_addr <= mem_base_q[MEM_AW+1:2];
            // Read bursts use Memory Read Multiple unless prefetch is barred; write bursts use plain Memory Write
            if (wdata_q[pmd_pkg::CTRL_DIR]) begin
              cmd_q <= pmd_pkg::CMD_MEM_WR;
            end else if (wdata_q[pmd_pkg::CTRL_NPF]) begin
              cmd_q <= pmd_pkg::CMD_MEM_RD;
            end else begin
              cmd_q <= pmd_pkg::CMD_MEM_RD_MULT;
            end
            st_q <= pmd_pkg::ST_REQ;
          end else if (start && size_q != 32'h0000_0000) begin
            busy_q <= 1'b1;
            da_q <= 1'b0;
            addr_q <= pci_base_q;
            cnt_q <= size_q >> 2;
            mem_addr <= mem_base_q[MEM_AW+1:2];
            cmd_q <= wdata_q[pmd_pkg::CTRL_DIR] ? pmd_pkg::CMD_MEM_WR :
              (wdata_q[pmd_pkg::CTRL_NPF] ? pmd_pkg::CMD_MEM_RD : pmd_pkg::CMD_MEM_RD_MULT);
            st_q <= pmd_pkg::ST_REQ;
          end else if (wr_fire && da_hit_w) begin
            busy_q <= 1'b1;
            da_q <= 1'b1;
            da_wr_q <= 1'b1;
            addr_q <= da_base_q + {24'h000000, awaddr_q & ~pmd_pkg::ADDR_DA_MASK};
            da_wdata_q <= wdata_q;
            cmd_q <= da_cmd_q;
            cnt_q <= 32'h0000_0001;
            st_q <= pmd_pkg::ST_REQ;
          end else if (ar_pend_q && da_hit_r && !da_resp_q) begin
            busy_q <= 1'b1;
            da_q <= 1'b1;
            da_wr_q <= 1'b0;
            addr_q <= da_base_q + {24'h000000, ar_q_addr & ~pmd_pkg::ADDR_DA_MASK};
            cmd_q <= da_cmd_q;
            cnt_q <= 32'h0000_0001;
            st_q <= pmd_pkg::ST_REQ;
          end
        end
        pmd_pkg::ST_REQ: begin
          pci_o.req_n <= 1'b0;
          if (!pci_gnt_n && !pci_o.req_n) begin
            st_q <= pmd_pkg::ST_ADDR;
          end
        end
        pmd_pkg::ST_ADDR: begin
          pci_o.frame_n <= 1'b0;
          pci_o.ad <= addr_q;
          pci_o.ad_oe <= 1'b1;
          pci_o.cbe_n <= cmd_q;
          pci_o.req_n <= 1'b1;
          last_q <= cnt_q == 32'h0000_0001;
          st_q <= pmd_pkg::ST_DATA;
          rd_pend_q <= 1'b0;
          wait_q <= 2'h0;
        end
        pmd_pkg::ST_DATA: begin
          // Data phases always full dword
          pci_o.cbe_n <= da_q ? 4'h0 : pmd_pkg::BE_ALL;
          pci_o.irdy_n <= (wait_q == pmd_pkg::FETCH_WAIT);
          if (wait_q != 2'h0) begin
            wait_q <= wait_q - 1'b1;
          end
          // Frame may only drop together with irdy
          if (last_q && wait_q != pmd_pkg::FETCH_WAIT) begin
            pci_o.frame_n <= 1'b1;
          end
          if (da_q ? da_wr_q : write_dir) begin
            pci_o.ad <= da_q ? da_wdata_q : mem_rdata;
          end else begin
            pci_o.ad_oe <= 1'b0;
          end
          if (!pci_o.irdy_n && !pci_trdy_n && !pci_devsel_n) begin
            cnt_q <= cnt_q - 32'h0000_0001;
            addr_q <= addr_q + 32'h0000_0004;
            if (!da_q && write_dir) begin
              mem_addr <= mem_addr + 1'b1;
              // Next word is two cycles away from the memory
              if (cnt_q != 32'h0000_0001) begin
                wait_q <= pmd_pkg::FETCH_WAIT;
                pci_o.irdy_n <= 1'b1;
              end
            end
            if (!(da_q ? da_wr_q : write_dir)) begin
              mem_we <= !da_q;
              mem_wdata <= pci_ad_i;
              da_rdata_q <= pci_ad_i;
            end
            last_q <= cnt_q == 32'h0000_0002;
            if (cnt_q == 32'h0000_0001 || !pci_stop_n) begin
              st_q <= pmd_pkg::ST_TURN;
              pci_o.frame_n <= 1'b1;
              pci_o.irdy_n <= 1'b1;
            end
          end else if (!pci_stop_n && !pci_o.irdy_n) begin
            // Retry or disconnect without data: release and rearbitrate
            st_q <= pmd_pkg::ST_TURN;
            pci_o.frame_n <= 1'b1;
            pci_o.irdy_n <= 1'b1;
          end
        end
        pmd_pkg::ST_TURN: begin
          pci_o.ad_oe <= 1'b0;
          pci_o.cbe_n <= 4'hf;
          st_q <= (cnt_q == 32'h0000_0000) ? pmd_pkg::ST_DONE : pmd_pkg::ST_REQ;
        end
        pmd_pkg::ST_DONE: begin
          busy_q <= 1'b0;
          da_resp_q <= da_q;
          st_q <= pmd_pkg::ST_IDLE;
        end
        default: st_q <= pmd_pkg::ST_IDLE;
      endcase
    end
  end

  chk_done_irq_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_q && mask_q) |=> irq_out) else $error("irq not raised");
  chk_no_irq_unmasked: assert property (@(posedge aclk) disable iff (!aresetn)
    !mask_q |=> !irq_out) else $error("irq while masked");
  chk_req_before_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pci_o.frame_n) |-> $past(!pci_gnt_n) && $past(!pci_o.req_n, 2)) else $error("frame without grant");
  chk_dma_full_be: assert property (@(posedge aclk) disable iff (!aresetn)
    (!pci_o.irdy_n && !da_q) |-> pci_o.cbe_n == pmd_pkg::BE_ALL) else $error("partial byte enables");
  chk_dir_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(pci_o.frame_n) && !da_q && write_dir) |-> pci_o.cbe_n == pmd_pkg::CMD_MEM_WR) else $error("bad write cmd");
  chk_nopref_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(pci_o.frame_n) && !da_q && !write_dir && ctrl_q[pmd_pkg::CTRL_NPF])
      |-> pci_o.cbe_n == pmd_pkg::CMD_MEM_RD) else $error("prefetch read used");
  chk_done_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == pmd_pkg::ST_DONE && !da_q) |=> done_q) else $error("done flag missing");
  chk_base_aligned: assert property (@(posedge aclk) disable iff (!aresetn)
    pci_base_q[1:0] == 2'h0 && size_q[1:0] == 2'h0 && mem_base_q[1:0] == 2'h0) else $error("low bits kept");
  chk_da_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(pci_o.frame_n) && da_q) |-> pci_o.cbe_n == da_cmd_q) else $error("wrong direct cmd");
endmodule
`default_nettype wire

// ### rtl/pmd_pkg.sv
/*
  Package for the PCI bus-master DMA and direct-access engine: register map,
  field positions, masks, PCI commands, states and carrier structs.
  Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
*/
package pmd_pkg;
  localparam logic [7:0] ADDR_MEM_BASE = 8'h00;
  localparam logic [7:0] ADDR_PCI_BASE = 8'h04;
  localparam logic [7:0] ADDR_SIZE = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_LOCAL_INTERRUPT_REG = 8'h10;
  localparam logic [7:0] ADDR_DA_BASE = 8'h14;
  localparam logic [7:0] ADDR_DA_CMD = 8'h18;
  localparam logic [7:0] ADDR_DA_WIN = 8'h80;
  localparam logic [7:0] ADDR_DA_MASK = 8'h80;
  localparam int CTRL_DIR = 0;
  localparam int CTRL_NPF = 1;
  localparam int CTRL_LOWN = 2;
  localparam int CTRL_POWN = 3;
  localparam int LOCAL_INTERRUPT_REG_DONE = 5;
  localparam int LOCAL_INTERRUPT_REG_MASK = 21;
  localparam int MEM_AW = 12;
  localparam logic [31:0] DWORD_MASK = 32'hffff_fffc;
  localparam logic [31:0] SIZE_MASK = 32'h0000_7ffc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BE_ALL = 4'h0;
  // Master wait states after a write beat, covering the memory read latency
  localparam logic [1:0] FETCH_WAIT = 2'h2;
  localparam logic [3:0] CMD_INTA = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_REQ = 3'h1,
    ST_ADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_TURN = 3'h6,
    ST_DONE = 3'h7
  } pmd_state_type;

  typedef struct packed {
    logic req_n;
    logic frame_n;
    logic irdy_n;
    logic [31:0] ad;
    logic ad_oe;
    logic [3:0] cbe_n;
  } pmd_pci_out_type;
endpackage

// ### dv/pmd_pci_partner.sv
/*
  PCI far side for the bus-master engine: arbiter that grants on request,
  and one target that claims every address, records cycles and serves reads.
  Assumes PCI signals synchronous to aclk and one master on the bus.
*/
`timescale 1ns/100ps
`default_nettype none
module pmd_pci_partner (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire pmd_pkg::pmd_pci_out_type pci_o, // Master drive
  input wire logic slow, // Insert target wait states
  output logic gnt_n, // Grant
  output logic trdy_n, // Target ready
  output logic devsel_n, // Claimed
  output logic stop_n, // Never stops
  output logic [31:0] ad_i // Read data
);
  logic busy_q, tog_q, be_bad, gnt_bad;
  logic [31:0] addr_q, last_q;
  logic [3:0] cmd_q;
  logic [31:0] wr [0:15];
  int nx;
  function automatic logic [31:0] pat(input logic [31:0] a);
    return a ^ 32'h5ac3_0f96;
  endfunction
  assign stop_n = 1'b1;
  // Released bus shows the inverse of its last value, not a stale copy
  assign ad_i = (busy_q && !trdy_n && !cmd_q[0]) ? pat(addr_q + 32'(nx) * 4) : ~last_q;
  always_ff @(posedge aclk) begin
    last_q <= ad_i;
    if (!aresetn) begin
      gnt_n <= 1'b1;
      trdy_n <= 1'b1;
      devsel_n <= 1'b1;
      busy_q <= 1'b0;
      tog_q <= 1'b0;
      be_bad <= 1'b0;
      gnt_bad <= 1'b0;
      nx <= 0;
    end else begin
      gnt_n <= pci_o.req_n;
      tog_q <= ~tog_q;
      if (!busy_q && !pci_o.frame_n) begin
        busy_q <= 1'b1;
        addr_q <= pci_o.ad;
        cmd_q <= pci_o.cbe_n;
        nx <= 0;
        devsel_n <= 1'b0;
        if (gnt_n) gnt_bad <= 1'b1;
      end else if (busy_q) begin
        trdy_n <= slow & tog_q;
        if (!pci_o.irdy_n && !trdy_n) begin
          if (pci_o.cbe_n !== pmd_pkg::BE_ALL) be_bad <= 1'b1;
          wr[nx[3:0]] <= pci_o.ad;
          nx <= nx + 1;
          if (pci_o.frame_n) begin
            busy_q <= 1'b0;
            devsel_n <= 1'b1;
            trdy_n <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
/*
  Testbench for pmd_engine: AXI4-Lite register tasks, shared memory and PCI partner.
  Assumes the register map and command choices of the package.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} pmd_row_type;
  localparam pmd_row_type ROWS [6] = '{'{8'h00, 32'h0000_0123, 32'h0000_0120, 2'h0},
    '{8'h04, 32'hffff_fff3, 32'hffff_fff0, 2'h0}, '{8'h08, 32'h0001_8007, 32'h0000_0004, 2'h0},
    '{8'h14, 32'h8000_1000, 32'h8000_1000, 2'h0}, '{8'h18, 32'h0000_0005, 32'h0000_0005, 2'h0},
    '{8'h40, 32'h1234_5678, 32'h0000_0000, 2'h2}};
  localparam logic [3:0] CMDS [8] = '{4'ha, 4'hb, 4'h2, 4'h3, 4'h6, 4'h7, 4'h1, 4'h0};
  localparam logic [7:0] IS_RD = 8'h95;
  int fails = 0;
  int checks = 0;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slow = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, mem_rdata = 0, rdata, mem_wdata, ad_i, d;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, mem_we, gnt_n, trdy_n, devsel_n, stop_n, irq_out;
  logic [1:0] bresp, rresp, r;
  logic [11:0] mem_addr;
  logic [31:0] mem [0:4095];
  pmd_pkg::pmd_pci_out_type pci_o;
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem[mem_addr];
  end
  pmd_engine dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pci_o(pci_o), .pci_gnt_n(gnt_n), .pci_trdy_n(trdy_n),
    .pci_devsel_n(devsel_n), .pci_stop_n(stop_n), .pci_ad_i(ad_i), .irq_out(irq_out));
  pmd_pci_partner part (.aclk(aclk), .aresetn(aresetn), .pci_o(pci_o), .slow(slow), .gnt_n(gnt_n),
    .trdy_n(trdy_n), .devsel_n(devsel_n), .stop_n(stop_n), .ad_i(ad_i));
  task automatic conclude;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s);
    bit ta, tw;
    int n;
    ta = 0;
    tw = 0;
    n = 0;
    awaddr <= a;
    wdata <= dd;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    forever begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin ta = 1; awvalid <= 0; end
      if (!tw && wready === 1'b1) begin tw = 1; wvalid <= 0; end
      if (bvalid === 1'b1) begin r = bresp; break; end
      if (++n > 3000) begin fails++; break; end
    end
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) begin d = rdata; r = rresp; break; end
      if (++n > 3000) begin fails++; break; end
    end
    rready <= 0;
    @(posedge aclk);
  endtask
  // Polling keeps the wait bounded even if completion never comes
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      axr(pmd_pkg::ADDR_LOCAL_INTERRUPT_REG);
      n++;
    end while (d[pmd_pkg::LOCAL_INTERRUPT_REG_DONE] !== 1'b1 && n < 300);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    `CHK(pci_o.req_n, 1'b1)
    axr(pmd_pkg::ADDR_CTRL);
    `CHK(d, 32'h0)
    axr(pmd_pkg::ADDR_LOCAL_INTERRUPT_REG);
    `CHK(d, 32'h0)
    for (int i = 0; i < 6; i++) begin
      axw(ROWS[i].a, ROWS[i].d, 4'hf);
      `CHK(r, ROWS[i].r)
      axr(ROWS[i].a);
      `CHK(d, ROWS[i].e)
      `CHK(r, ROWS[i].r)
    end
    for (int i = 0; i < 4; i++) mem[16 + i] = 32'h1111_0000 + i;
    axw(pmd_pkg::ADDR_LOCAL_INTERRUPT_REG, 32'h0020_0000, 4'h4);
    axw(pmd_pkg::ADDR_MEM_BASE, 32'h40, 4'hf);
    axw(pmd_pkg::ADDR_PCI_BASE, 32'h1000_0003, 4'hf);
    axw(pmd_pkg::ADDR_SIZE, 32'h10, 4'hf);
    axw(pmd_pkg::ADDR_CTRL, 32'h1, 4'h1);
    wait_done;
    `CHK(d[5], 1'b1)
    `CHK(part.cmd_q, pmd_pkg::CMD_MEM_WR)
    `CHK(part.addr_q, 32'h1000_0000)
    `CHK(part.nx, 4)
    `CHK(part.be_bad, 1'b0)
    `CHK(part.gnt_bad, 1'b0)
    for (int i = 0; i < 4; i++) `CHK(part.wr[i], 32'h1111_0000 + i)
    `CHK(irq_out, 1'b1)
    axw(pmd_pkg::ADDR_LOCAL_INTERRUPT_REG, 32'h20, 4'h1);
    `CHK(irq_out, 1'b0)
    axw(pmd_pkg::ADDR_LOCAL_INTERRUPT_REG, 32'h0, 4'h4);
    slow <= 1;
    for (int k = 0; k < 2; k++) begin
      axw(pmd_pkg::ADDR_MEM_BASE, 32'h100, 4'hf);
      axw(pmd_pkg::ADDR_PCI_BASE, 32'h2000_0000 + k * 32'h100, 4'hf);
      axw(pmd_pkg::ADDR_SIZE, 32'h8, 4'hf);
      axw(pmd_pkg::ADDR_CTRL, k ? 32'he : 32'h0, 4'h1);
      axr(pmd_pkg::ADDR_CTRL);
      `CHK(d[3:0], k ? 4'he : 4'h0)
      wait_done;
      `CHK(part.cmd_q, k ? pmd_pkg::CMD_MEM_RD : pmd_pkg::CMD_MEM_RD_MULT)
      `CHK(irq_out, 1'b0)
      for (int j = 0; j < 2; j++) `CHK(mem[64 + j], part.pat(32'h2000_0000 + k * 32'h100 + j * 4))
      axw(pmd_pkg::ADDR_LOCAL_INTERRUPT_REG, 32'h20, 4'h1);
    end
    slow <= 0;
    axw(pmd_pkg::ADDR_DA_BASE, 32'h3000_0000, 4'hf);
    for (int i = 0; i < 8; i++) begin
      axw(pmd_pkg::ADDR_DA_CMD, 32'(CMDS[i]), 4'hf);
      if (IS_RD[i]) begin
        axr(8'ha4);
        `CHK(d, part.pat(32'h3000_0024))
      end else begin
        axw(8'ha4, 32'hbeef_0000 + i, 4'hf);
        `CHK(part.wr[0], 32'hbeef_0000 + i)
      end
      `CHK(part.addr_q, 32'h3000_0024)
      `CHK(part.cmd_q, CMDS[i])
    end
    conclude();
  end
  // Whole sequence needs a few hundred cycles
  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
